// ### rtl/buck_softstart_fault_supervisor.sv
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module buck_softstart_fault_supervisor #(
   parameter int PG_DELAY = buck_supervisor_pkg::PG_DELAY_CYCLES,
   parameter int SS_TICK = buck_supervisor_pkg::SS_TICK_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire buck_supervisor_pkg::sense_s sense,
   input wire logic [buck_supervisor_pkg::ADDR_W-1:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrStrobe,
   input wire logic regRdStrobe,
   output logic [31:0] regRdData,
   output buck_supervisor_pkg::drive_s drive,
   output logic [buck_supervisor_pkg::REF_W-1:0] refCode,
   output logic rampDone,
   output logic powerOkOut,
   output logic powerOkOe,
   output logic biasRegEnable,
   output logic biasRegNormal
);
   import buck_supervisor_pkg::*;

   localparam int PG_W = $clog2(PG_DELAY + 1);

   // =========================================================
   // parameter check
   generate
      if (PG_DELAY < 1 || PG_W > 24) begin : g_bad_delay
         $error("PG_DELAY out of range");
      end
      // ramp tick counter is eight bits wide
      if (SS_TICK < 1 || SS_TICK > 256) begin : g_bad_tick
         $error("SS_TICK out of range");
      end
   endgenerate

   typedef struct packed {
      sup_state_e state;
      sense_s sync1;
      sense_s sync2;
      logic biasOk;
      logic [7:0] tickCnt;
      logic [REF_W-1:0] refCode;
      logic rampDone;
      logic [9:0] ovCnt;
      logic [3:0] uvCnt;
      logic [PG_W-1:0] pgCnt;
      logic pgDelayDone;
      logic pgUnder;
      logic ovLatch;
      logic uvLatch;
      logic otLatch;
      drive_s drive;
      logic powerOkOe;
      logic biasEn;
      logic biasNormal;
      logic forceOff;
      logic [31:0] rdData;
   } sup_s;

   localparam logic [7:0] TICK_LAST = 8'(SS_TICK - 1);
   localparam logic [REF_W-1:0] REF_FINAL = REF_W'(REF_FINAL_CODE);
   localparam logic [9:0] OV_LAST = 10'(OV_FILTER_CYCLES - 1);
   localparam logic [3:0] UV_LAST = 4'(UV_FILTER_CYCLES - 1);
   localparam logic [PG_W-1:0] PG_LAST = PG_W'(PG_DELAY - 1);

   sup_s s_q;
   sup_s s_d;
   sense_s sn;
   logic por;
   logic anyFault;
   logic enabled;

   // =========================================================
   // next-state logic
   always_comb begin
      s_d = s_q;
      // two-stage synchroniser; only sync2 is used below
      s_d.sync1 = sense;
      s_d.sync2 = s_q.sync1;
      sn = s_q.sync2;

      // bias rail lockout with hysteresis
      if (sn.biasAboveRise) begin
         s_d.biasOk = 1'b1;
      end else if (!sn.biasAboveFall) begin
         s_d.biasOk = 1'b0;
      end
      por = s_d.biasOk & ~s_q.biasOk;
      enabled = sn.enAboveHigh & s_d.biasOk;

      // bias regulator control
      s_d.biasEn = sn.enAboveLow;
      s_d.biasNormal = sn.enAboveLow & sn.biasAboveRise;

      // fault latch clears: enable low (otLatch only once overTemp is low) or power-on clear
      if (!sn.enAboveHigh || por) begin
         s_d.ovLatch = 1'b0;
         s_d.uvLatch = 1'b0;
         if (!sn.overTemp || por) begin
            s_d.otLatch = 1'b0;
         end
      end

      // over-voltage filter, armed whenever enabled
      if (enabled && sn.outAboveOv) begin
         if (s_q.ovCnt == OV_LAST) begin
            s_d.ovLatch = 1'b1;
         end else begin
            s_d.ovCnt = s_q.ovCnt + 10'h001;
         end
      end else begin
         s_d.ovCnt = 10'h000;
      end

      // under-voltage: eight consecutive low samples once regulating
      if (s_q.state == ST_RUN && sn.outBelowUv) begin
         if (s_q.uvCnt == UV_LAST) begin
            s_d.uvLatch = 1'b1;
         end else begin
            s_d.uvCnt = s_q.uvCnt + 4'h1;
         end
      end else begin
         s_d.uvCnt = 4'h0;
      end

      // over-temperature; set wins over a same-cycle clear
      if (sn.enAboveHigh && sn.overTemp) begin
         s_d.otLatch = 1'b1;
      end
      anyFault = s_d.ovLatch | s_d.uvLatch | s_d.otLatch;

      // sequencing
      if (!s_d.biasOk) begin
         s_d.state = ST_LOCKOUT;
      end else if (anyFault) begin
         s_d.state = ST_FAULT;
      end else if (!sn.enAboveHigh || s_q.forceOff) begin
         s_d.state = ST_IDLE;
      end else begin
         case (s_q.state)
            ST_LOCKOUT, ST_IDLE, ST_FAULT: begin
               s_d.state = ST_SOFTSTART;
            end
            ST_SOFTSTART: begin
               if (s_q.rampDone) begin
                  s_d.state = ST_RUN;
               end
            end
            ST_RUN: begin
               s_d.state = ST_RUN;
            end
            default: begin
               s_d.state = ST_LOCKOUT;
            end
         endcase
      end
      if (por && s_d.state == ST_RUN) begin
         s_d.state = ST_SOFTSTART;
      end

      // reference ramp
      if (s_d.state != ST_SOFTSTART && s_d.state != ST_RUN) begin
         s_d.tickCnt = 8'h00;
         s_d.refCode = '0;
         s_d.rampDone = 1'b0;
      end else if (s_q.state != ST_SOFTSTART && s_d.state == ST_SOFTSTART) begin
         s_d.tickCnt = 8'h00;
         s_d.refCode = '0;
         s_d.rampDone = 1'b0;
      end else if (s_d.state == ST_SOFTSTART && !s_q.rampDone) begin
         if (s_q.tickCnt == TICK_LAST) begin
            s_d.tickCnt = 8'h00;
            s_d.refCode = s_q.refCode + REF_W'(1);
            if (s_q.refCode + REF_W'(1) == REF_FINAL) begin
               s_d.rampDone = 1'b1;
            end
         end else begin
            s_d.tickCnt = s_q.tickCnt + 8'h01;
         end
      end

      // gate drives, chosen from the next state
      case (s_d.state)
         ST_SOFTSTART, ST_RUN: begin
            s_d.drive.driveEnable = 1'b1;
            if (s_q.drive.highSideDrive) begin
               if (sn.onTimeDone) begin
                  s_d.drive.highSideDrive = 1'b0;
                  s_d.drive.lowSideDrive = 1'b1;
               end
            end else if (sn.outBelowRef) begin
               s_d.drive.highSideDrive = 1'b1;
               s_d.drive.lowSideDrive = 1'b0;
            end else if (s_d.state == ST_SOFTSTART && sn.zeroCross) begin
               s_d.drive.lowSideDrive = 1'b0;
            end
         end
         ST_FAULT: begin
            // under-voltage alone pulls both low; others tri-state
            s_d.drive.highSideDrive = 1'b0;
            s_d.drive.lowSideDrive = 1'b0;
            s_d.drive.driveEnable = s_d.uvLatch & ~s_d.ovLatch & ~s_d.otLatch;
         end
         default: begin
            s_d.drive.highSideDrive = 1'b0;
            s_d.drive.lowSideDrive = 1'b0;
            s_d.drive.driveEnable = 1'b0;
         end
      endcase

      // power ok: under-range latch and post-regulation delay
      if (sn.outAtNominal) begin
         s_d.pgUnder = 1'b0;
      end
      if (sn.outBelowPg) begin
         s_d.pgUnder = 1'b1;
      end
      if (s_d.state != ST_RUN) begin
         s_d.pgCnt = '0;
         s_d.pgDelayDone = 1'b0;
      end else if (!s_q.pgDelayDone && sn.outAtNominal) begin
         if (s_q.pgCnt == PG_LAST) begin
            s_d.pgDelayDone = 1'b1;
         end else begin
            s_d.pgCnt = s_q.pgCnt + PG_W'(1);
         end
      end
      s_d.powerOkOe = ~(s_d.state == ST_RUN && s_d.pgDelayDone && !s_d.pgUnder
         && !sn.outAboveOv && !s_d.ovLatch);

      // register port
      if (regWrStrobe && regAddr == CTRL_OFFSET) begin
         s_d.forceOff = regWrData[CTRL_FORCE_OFF_BIT];
      end
      if (regRdStrobe) begin
         case (regAddr)
            CTRL_OFFSET: begin
               s_d.rdData = {31'h00000000, s_q.forceOff};
            end
            STATUS_OFFSET: begin
               s_d.rdData = 32'h00000000;
               s_d.rdData[ST_STATE_LSB +: 5] = s_q.state;
               s_d.rdData[ST_OV_BIT] = s_q.ovLatch;
               s_d.rdData[ST_UV_BIT] = s_q.uvLatch;
               s_d.rdData[ST_OT_BIT] = s_q.otLatch;
               s_d.rdData[ST_BIAS_OK_BIT] = s_q.biasOk;
               s_d.rdData[ST_POWER_OK_BIT] = ~s_q.powerOkOe;
               s_d.rdData[ST_RAMP_DONE_BIT] = s_q.rampDone;
            end
            REFCODE_OFFSET: begin
               s_d.rdData = {23'h000000, s_q.refCode};
            end
            default: begin
               s_d.rdData = 32'h00000000;
            end
         endcase
      end else begin
         s_d.rdData = 32'h00000000;
      end
   end

   // =========================================================
   // state register
   always_ff @(posedge clk) begin
      if (reset) begin
         s_q <= '0;
         s_q.state <= ST_LOCKOUT;
         s_q.powerOkOe <= 1'b1;
         s_q.forceOff <= CTRL_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from flops
   assign regRdData = s_q.rdData;
   assign drive = s_q.drive;
   assign refCode = s_q.refCode;
   assign rampDone = s_q.rampDone;
   assign powerOkOut = 1'b0 & s_q.powerOkOe; // open drain only pulls low
   assign powerOkOe = s_q.powerOkOe;
   assign biasRegEnable = s_q.biasEn;
   assign biasRegNormal = s_q.biasNormal;

endmodule // buck_softstart_fault_supervisor
`default_nettype wire

// ### rtl/buck_supervisor_pkg.sv
`default_nettype none
package buck_supervisor_pkg;

   // =========================================================
   // timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int SS_TICK_NS = 2000;                  // ~500 kHz ramp oscillator
   localparam int SS_TICK_CYCLES = (SS_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OV_FILTER_NS = 5000;
   localparam int OV_FILTER_CYCLES = (OV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PG_DELAY_NS = 1000000;
   localparam int PG_DELAY_CYCLES = (PG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int UV_FILTER_CYCLES = 8;

   // =========================================================
   // reference ramp
   localparam int REF_FINAL_UV = 750000;
   localparam int REF_STEP_UV = 1800;
   localparam int REF_FINAL_CODE = (REF_FINAL_UV + REF_STEP_UV - 1) / REF_STEP_UV;
   localparam int REF_W = 9;

   // =========================================================
   // register map
   localparam int ADDR_W = 4;
   localparam logic [3:0] CTRL_OFFSET = 4'h0;
   localparam logic [3:0] STATUS_OFFSET = 4'h4;
   localparam logic [3:0] REFCODE_OFFSET = 4'h8;
   localparam int CTRL_FORCE_OFF_BIT = 0;
   localparam logic CTRL_RESET = 1'b0;
   localparam int ST_STATE_LSB = 0;
   localparam int ST_OV_BIT = 5;
   localparam int ST_UV_BIT = 6;
   localparam int ST_OT_BIT = 7;
   localparam int ST_BIAS_OK_BIT = 8;
   localparam int ST_POWER_OK_BIT = 9;
   localparam int ST_RAMP_DONE_BIT = 10;

   // =========================================================
   // types
   typedef enum logic [4:0] {
      ST_LOCKOUT = 5'b00001,
      ST_IDLE = 5'b00010,
      ST_SOFTSTART = 5'b00100,
      ST_RUN = 5'b01000,
      ST_FAULT = 5'b10000
   } sup_state_e;

   // digitised comparator and enable levels, all active high
   typedef struct packed {
      logic enAboveLow;     // enable above bias-regulator threshold
      logic enAboveHigh;    // enable above switcher threshold
      logic biasAboveRise;  // bias rail above rising lockout level
      logic biasAboveFall;  // bias rail above falling lockout level
      logic outBelowRef;    // feedback below active reference
      logic outBelowPg;     // feedback ten percent under nominal
      logic outAtNominal;   // feedback back at nominal
      logic outAboveOv;     // feedback above over-voltage threshold
      logic outBelowUv;     // feedback at or under seventy-five percent
      logic zeroCross;      // inductor current reached zero
      logic onTimeDone;     // on-time one-shot expired
      logic overTemp;       // over-temperature indication
   } sense_s;

   typedef struct packed {
      logic highSideDrive;
      logic lowSideDrive;
      logic driveEnable;    // low: both power switches tri-stated
   } drive_s;

endpackage
`default_nettype wire

// ### tb/buck_softstart_fault_supervisor_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module buck_softstart_fault_supervisor_assertions #(
   parameter int PG_DELAY = 20
) (
   input wire logic clk,
   input wire logic reset,
   input wire buck_supervisor_pkg::sense_s sense,
   input wire buck_supervisor_pkg::drive_s drive,
   input wire logic [buck_supervisor_pkg::REF_W-1:0] refCode,
   input wire logic rampDone,
   input wire logic powerOkOut,
   input wire logic powerOkOe,
   input wire logic biasRegEnable
);
   import buck_supervisor_pkg::*;
   // ==========
   // clocking and reset history
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   logic [2:0] rstHist_q;
   logic settled;
   // synchroniser path free of reset for three edges
   always_ff @(posedge clk) begin
      rstHist_q <= {rstHist_q[1:0], reset};
   end
   assign settled = (rstHist_q == 3'h0);
   // ==========
   // properties
   AST_REF_STEP: assert property (
      refCode != $past(refCode) |-> refCode == $past(refCode) + 9'h1 || refCode == 9'h0)
      else $error("reference code jumped");
   AST_REF_FINAL: assert property (
      $rose(rampDone) |-> refCode == 9'(REF_FINAL_CODE))
      else $error("ramp ended off the final code");
   AST_PG_RAMP: assert property (
      !rampDone |-> powerOkOe)
      else $error("power ok released before ramp end");
   AST_PG_OV: assert property (
      settled && $past(sense.outAboveOv, 3) |-> powerOkOe)
      else $error("power ok released during over-voltage");
   AST_OD_DATA: assert property (
      powerOkOut == 1'b0)
      else $error("open drain data not low");
   AST_TRISTATE: assert property (
      !drive.driveEnable |-> !drive.highSideDrive && !drive.lowSideDrive)
      else $error("gate on while tri-stated");
   AST_OT_OFF: assert property (
      settled && $past(sense.overTemp, 3) |-> !drive.driveEnable)
      else $error("over-temperature not shut off");
   AST_ONE_SIDE: assert property (
      !(drive.highSideDrive && drive.lowSideDrive))
      else $error("both gates on");
   AST_REF_HOLD: assert property (
      rampDone && $past(rampDone) |-> refCode == $past(refCode))
      else $error("reference moved after ramp end");
   AST_BIAS_EN: assert property (
      settled |-> biasRegEnable == $past(sense.enAboveLow, 3))
      else $error("bias regulator enable off its pin");
endmodule // buck_softstart_fault_supervisor_assertions
bind buck_softstart_fault_supervisor buck_softstart_fault_supervisor_assertions #(
   .PG_DELAY(PG_DELAY)
) u_chk (.clk(clk), .reset(reset), .sense(sense), .drive(drive), .refCode(refCode),
   .rampDone(rampDone), .powerOkOut(powerOkOut), .powerOkOe(powerOkOe),
   .biasRegEnable(biasRegEnable));
`default_nettype wire

// ### tb/buck_softstart_fault_supervisor_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module buck_softstart_fault_supervisor_tb_top;
   import buck_supervisor_pkg::*;
   localparam int PGD = 20;
   localparam int SST = 4;
   logic clk = 1'b0;
   logic reset = 1'b1;
   sense_s sense = '0;
   logic [ADDR_W-1:0] regAddr = '0;
   logic [31:0] regWrData = '0;
   logic regWrStrobe = 1'b0;
   logic regRdStrobe = 1'b0;
   logic rdSeen = 1'b0;
   logic [31:0] regRdData;
   drive_s drive;
   logic [REF_W-1:0] refCode;
   logic rampDone, powerOkOut, powerOkOe, biasRegEnable, biasRegNormal;
   logic [63:0] expQ[$];
   int nMismatch = 0;
   int nTests = 0;
   int cycles = 0;
   int rnd;
   // ==========
   // clock and device
   initial begin
      forever #4 clk = ~clk;
   end
   buck_softstart_fault_supervisor #(.PG_DELAY(PGD), .SS_TICK(SST))
      u_buck_softstart_fault_supervisor (
      .clk(clk), .reset(reset), .sense(sense), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
      .drive(drive), .refCode(refCode), .rampDone(rampDone), .powerOkOut(powerOkOut),
      .powerOkOe(powerOkOe), .biasRegEnable(biasRegEnable), .biasRegNormal(biasRegNormal));
   // ==========
   // helpers
   task automatic completeRun();
      $display("comparisons %0d mismatches %0d", nTests, nMismatch);
      if (nMismatch == 0 && nTests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      nTests++;
      if (got !== exp) begin
         nMismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrStrobe <= 1'b1;
      @(posedge clk);
      regWrStrobe <= 1'b0;
   endtask
   // note the expected word and mask, then issue the read
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      expQ.push_back({m, e});
      @(posedge clk);
      regAddr <= a;
      regRdStrobe <= 1'b1;
      @(posedge clk);
      regRdStrobe <= 1'b0;
      @(posedge clk);
   endtask
   task automatic toggleEn();
      sense.enAboveHigh <= 1'b0;
      cyc(6);
      sense.enAboveHigh <= 1'b1;
      cyc(6);
   endtask
   // read data monitor and hang limit
   always @(posedge clk) begin : mon
      logic [63:0] e;
      cycles++;
      if (rdSeen) begin
         e = expQ.pop_front();
         chk("regRdData", e[31:0], regRdData & e[63:32]);
      end
      rdSeen <= regRdStrobe;
      if (cycles == 10000) begin
         nMismatch++;
         completeRun();
      end
   end
   // ==========
   // main sequence
   initial begin
      rnd = $urandom(32'h7C1A89C7);
      cyc(4);
      reset <= 1'b0;
      cyc(1);
      chk("drive", 32'h0, drive);
      chk("powerOkOe", 32'h1, powerOkOe);
      rd(STATUS_OFFSET, 32'h1, 32'h1FF);
      rd(REFCODE_OFFSET, 32'h0, 32'hFFFFFFFF);
      rd(4'hC, 32'h0, 32'hFFFFFFFF);
      wr(STATUS_OFFSET, $urandom);
      wr(4'hC, $urandom);
      wr(CTRL_OFFSET, $urandom & 32'hFFFFFFFE);
      rd(CTRL_OFFSET, 32'h0, 32'h1);
      sense <= '{enAboveLow: 1'b1, biasAboveRise: 1'b1, biasAboveFall: 1'b1,
                 outAtNominal: 1'b1, default: 1'b0};
      cyc(6);
      chk("biasRegEnable", 32'h1, biasRegEnable);
      chk("biasRegNormal", 32'h1, biasRegNormal);
      chk("drive", 32'h0, drive);
      rd(STATUS_OFFSET, 32'h2, 32'h1F);
      sense.enAboveHigh <= 1'b1;
      cyc(6);
      rd(STATUS_OFFSET, 32'h104, 32'h1FF);
      // one switching cycle during soft start
      sense.outBelowRef <= 1'b1;
      cyc(1);
      sense.outBelowRef <= 1'b0;
      cyc(4);
      chk("drive", 32'h5, drive);
      sense.onTimeDone <= 1'b1;
      cyc(1);
      sense.onTimeDone <= 1'b0;
      cyc(4);
      chk("drive", 32'h3, drive);
      sense.zeroCross <= 1'b1;
      cyc(4);
      chk("drive", 32'h1, drive);
      sense.zeroCross <= 1'b0;
      for (int i = 0; i < 5000 && rampDone !== 1'b1; i++) cyc(1);
      chk("refCode", REF_FINAL_CODE, refCode);
      cyc(PGD - 4);
      chk("powerOkOe", 32'h1, powerOkOe);
      cyc(10);
      chk("powerOkOe", 32'h0, powerOkOe);
      sense.outAtNominal <= 1'b0;
      sense.outBelowPg <= 1'b1;
      cyc(1);
      sense.outBelowPg <= 1'b0;
      cyc(PGD + 6);
      chk("powerOkOe", 32'h1, powerOkOe);
      sense.outAtNominal <= 1'b1;
      cyc(PGD + 10);
      chk("powerOkOe", 32'h0, powerOkOe);
      // short over and under excursions are filtered
      sense.outAboveOv <= 1'b1;
      cyc(600);
      sense.outAboveOv <= 1'b0;
      cyc(6);
      chk("driveEnable", 32'h1, drive.driveEnable);
      rnd = 1 + $urandom % 7;
      sense.outBelowUv <= 1'b1;
      cyc(rnd);
      sense.outBelowUv <= 1'b0;
      cyc(6);
      chk("driveEnable", 32'h1, drive.driveEnable);
      // high side is on when the under-voltage shutdown lands
      sense.outBelowUv <= 1'b1;
      sense.outBelowRef <= 1'b1;
      cyc(1);
      sense.outBelowRef <= 1'b0;
      cyc(4);
      chk("drive", 32'h5, drive);
      cyc(7);
      chk("drive", 32'h1, drive);
      sense.outBelowUv <= 1'b0;
      rd(STATUS_OFFSET, 32'h150, 32'h1FF);
      toggleEn();
      chk("rampDone", 32'h0, rampDone);
      rd(STATUS_OFFSET, 32'h104, 32'h1FF);
      sense.outAboveOv <= 1'b1;
      cyc(640);
      chk("drive", 32'h0, drive);
      sense.outAboveOv <= 1'b0;
      cyc(10);
      chk("drive", 32'h0, drive);
      chk("powerOkOe", 32'h1, powerOkOe);
      rd(STATUS_OFFSET, 32'h130, 32'h1FF);
      toggleEn();
      rd(STATUS_OFFSET, 32'h104, 32'h1FF);
      sense.overTemp <= 1'b1;
      cyc(5);
      toggleEn();
      rd(STATUS_OFFSET, 32'h190, 32'h1FF);
      sense.overTemp <= 1'b0;
      toggleEn();
      rd(STATUS_OFFSET, 32'h104, 32'h1FF);
      wr(CTRL_OFFSET, 32'h1);
      cyc(4);
      rd(CTRL_OFFSET, 32'h1, 32'h1);
      rd(STATUS_OFFSET, 32'h2, 32'h1F);
      wr(CTRL_OFFSET, 32'h0);
      cyc(4);
      // bias rail hysteresis, lockout and power-on clear
      sense.biasAboveRise <= 1'b0;
      cyc(6);
      rd(STATUS_OFFSET, 32'h4, 32'h1F);
      sense.biasAboveFall <= 1'b0;
      cyc(6);
      chk("biasRegNormal", 32'h0, biasRegNormal);
      rd(STATUS_OFFSET, 32'h1, 32'h1FF);
      sense.biasAboveFall <= 1'b1;
      sense.biasAboveRise <= 1'b1;
      cyc(6);
      rd(STATUS_OFFSET, 32'h104, 32'h1FF);
      completeRun();
   end
endmodule // buck_softstart_fault_supervisor_tb_top
`default_nettype wire
